// [rtl/tit_pkg.sv]
// Package with register map, field layout and function codes of the triple interval timer
package tit_pkg;

    // ------------------------------------------------------------
    // Register map (port addresses)
    // ------------------------------------------------------------
    localparam logic [1:0] TIT_ADDR_CNT0 = 2'h0;
    localparam logic [1:0] TIT_ADDR_CNT1 = 2'h1;
    localparam logic [1:0] TIT_ADDR_CNT2 = 2'h2;
    localparam logic [1:0] TIT_ADDR_CTRL = 2'h3;

    // ------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------
    localparam int TIT_CW_SEL_HI  = 7;
    localparam int TIT_CW_SEL_LO  = 6;
    localparam int TIT_CW_ACC_HI  = 5;
    localparam int TIT_CW_ACC_LO  = 4;
    localparam int TIT_CW_FN_HI   = 3;
    localparam int TIT_CW_FN_LO   = 1;
    localparam int TIT_CW_BCD_BIT = 0;

    localparam logic [1:0] TIT_ACC_LATCH = 2'h0;
    localparam logic [1:0] TIT_ACC_LSB   = 2'h1;
    localparam logic [1:0] TIT_ACC_MSB   = 2'h2;
    localparam logic [1:0] TIT_ACC_WORD  = 2'h3;

    // ------------------------------------------------------------
    // Counting functions
    // ------------------------------------------------------------
    localparam logic [2:0] TIT_FN_TC_IRQ  = 3'h0;
    localparam logic [2:0] TIT_FN_ONESHOT = 3'h1;
    localparam logic [2:0] TIT_FN_RATE    = 3'h2;
    localparam logic [2:0] TIT_FN_SQUARE  = 3'h3;
    localparam logic [2:0] TIT_FN_SW_STB  = 3'h4;
    localparam logic [2:0] TIT_FN_HW_STB  = 3'h5;
    localparam logic [2:0] TIT_FN_EVENT   = 3'h6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  TIT_CW_RESET    = 8'h30;
    localparam logic [15:0] TIT_COUNT_RESET = 16'h0000;
    localparam logic [1:0]  TIT_SYNC_RESET  = 2'h0;

endpackage

// [rtl/tit_sync.sv]
// Two-stage synchroniser with rising-edge pulse for pin inputs
`timescale 1ns/1ps
module tit_sync
    import tit_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    logic [1:0] sync_r;
    logic       last_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_r <= TIT_SYNC_RESET;
        end else begin
            sync_r <= {sync_r[0], pin};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 1'b0;
        end else begin
            last_r <= sync_r[1];
        end
    end

    assign level = sync_r[1];
    assign rise  = sync_r[1] & ~last_r;
endmodule

// [rtl/tit_counter.sv]
// One 16-bit down counter with seven functions and binary or BCD counting
`timescale 1ns/1ps
module tit_counter
    import tit_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             cfg_we,
    input  wire logic [2:0]       cfg_fn,
    input  wire logic             cfg_bcd,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             sw_trig,
    input  wire logic             tick,
    input  wire logic             gate,
    input  wire logic             gate_rise,
    output logic [WIDTH-1:0]      count,
    output logic                  out
);
    logic [2:0]       fn_r;
    logic             bcd_r;
    logic [WIDTH-1:0] reload_r;
    logic [WIDTH-1:0] count_r;
    logic             armed_r;
    logic             out_r;
    logic             half_r;
    logic [WIDTH-1:0] dec;
    logic [WIDTH-1:0] half_pt;
    logic             run;

    // BCD or binary decrement, 0 wraps to the top value
    function automatic logic [WIDTH-1:0] tit_dec(input logic [WIDTH-1:0] v, input logic b);
        logic [WIDTH-1:0] r;
        logic             borrow;
        r = v;
        if (b) begin
            borrow = 1'b1;
            for (int i = 0; i < WIDTH / 4; i++) begin
                if (borrow) begin
                    if (v[i*4 +: 4] == 4'h0) begin
                        r[i*4 +: 4] = 4'h9;
                    end else begin
                        r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end else begin
            r = v - {{(WIDTH-1){1'b0}}, 1'b1};
        end
        return r;
    endfunction

    assign dec     = tit_dec(count_r, bcd_r);
    assign half_pt = {1'b0, reload_r[WIDTH-1:1]};
    assign run     = tick & armed_r & ((fn_r == TIT_FN_TC_IRQ || fn_r == TIT_FN_RATE
                     || fn_r == TIT_FN_SQUARE || fn_r == TIT_FN_EVENT) ? gate : 1'b1);

    // ------------------------------------------------------------
    // Function and count configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fn_r  <= TIT_FN_TC_IRQ;
            bcd_r <= 1'b0;
        end else if (cfg_we) begin
            fn_r  <= cfg_fn;
            bcd_r <= cfg_bcd;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_r <= TIT_COUNT_RESET;
        end else if (load) begin
            reload_r <= load_val;
        end
    end

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= TIT_COUNT_RESET;
            armed_r <= 1'b0;
            half_r  <= 1'b0;
        end else if (cfg_we) begin
            armed_r <= 1'b0;
            half_r  <= 1'b0;
        end else if (load) begin
            count_r <= load_val;
            half_r  <= 1'b0;
            // A count load is the software trigger of the one-shot
            armed_r <= !(cfg_fn_is_trig(fn_r)) || (fn_r == TIT_FN_ONESHOT && sw_trig);
        end else if ((fn_r == TIT_FN_ONESHOT && (gate_rise || sw_trig))
                     || (fn_r == TIT_FN_HW_STB && gate_rise)) begin
            count_r <= reload_r;
            armed_r <= 1'b1;
        end else if (run) begin
            if (count_r == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                unique case (fn_r)
                    TIT_FN_RATE: begin
                        count_r <= reload_r;
                    end
                    TIT_FN_SQUARE: begin
                        count_r <= reload_r;
                        half_r  <= 1'b0;
                    end
                    default: begin
                        count_r <= dec;
                        armed_r <= 1'b0;
                    end
                endcase
            end else begin
                count_r <= dec;
                // Low half starts when the count steps onto its midpoint
                if (fn_r == TIT_FN_SQUARE && dec == half_pt) begin
                    half_r <= 1'b1;
                end
            end
        end
    end

    function automatic logic cfg_fn_is_trig(input logic [2:0] f);
        return (f == TIT_FN_ONESHOT) || (f == TIT_FN_HW_STB);
    endfunction

    // ------------------------------------------------------------
    // Output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 1'b1;
        end else if (cfg_we) begin
            out_r <= (cfg_fn == TIT_FN_TC_IRQ || cfg_fn == TIT_FN_EVENT) ? 1'b0 : 1'b1;
        end else begin
            unique case (fn_r)
                TIT_FN_TC_IRQ, TIT_FN_EVENT: begin
                    if (load) begin
                        out_r <= 1'b0;
                    end else if (run && count_r == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                        out_r <= 1'b1;
                    end
                end
                TIT_FN_ONESHOT: begin
                    if (gate_rise || sw_trig) begin
                        out_r <= 1'b0;
                    end else if (run && count_r == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                        out_r <= 1'b1;
                    end
                end
                TIT_FN_RATE: begin
                    if (run) begin
                        out_r <= (count_r != {{(WIDTH-2){1'b0}}, 2'h2});
                    end
                end
                TIT_FN_SQUARE: begin
                    out_r <= ~half_r;
                end
                TIT_FN_SW_STB, TIT_FN_HW_STB: begin
                    if (tick) begin
                        out_r <= !(run && count_r == {{(WIDTH-1){1'b0}}, 1'b1});
                    end
                end
                default: begin
                    out_r <= 1'b1;
                end
            endcase
        end
    end

    assign count = count_r;
    assign out   = out_r;
endmodule

// [rtl/tit_top.sv]
// Top level of the triple interval timer: register port, latches and three counters
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module tit_top
    import tit_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    input  wire logic [2:0] cnt_clk,
    input  wire logic [2:0] cnt_gate,
    input  wire logic [2:0] evt_in,
    output logic [2:0]      cnt_out,
    output logic            baud_clk
);
    logic [7:0]  cw_r     [3];
    logic [7:0]  lsb_r    [3];
    logic [2:0]  wflip_r;
    logic [2:0]  rflip_r;
    logic [2:0]  latched_r;
    logic [15:0] latch_r  [3];
    logic [15:0] count    [3];
    logic [2:0]  clk_rise;
    logic [2:0]  evt_rise;
    logic [2:0]  gate_lvl;
    logic [2:0]  gate_rise;
    logic [7:0]  rdata_r;
    logic [1:0]  ctl_sel;

    assign ctl_sel = wdata[TIT_CW_SEL_HI:TIT_CW_SEL_LO];

    function automatic logic [7:0] tit_pick(input logic [15:0] v, input logic [1:0] acc,
                                            input logic flip);
        logic hi;
        hi = (acc == TIT_ACC_MSB) || (acc == TIT_ACC_WORD && flip);
        return hi ? v[15:8] : v[7:0];
    endfunction

    // ------------------------------------------------------------
    // Per-counter logic
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_ch
            logic        cfg_we;
            logic        wr_cnt;
            logic        load;
            logic [15:0] load_val;
            logic [1:0]  acc;
            logic        tick;

            assign acc    = cw_r[g][TIT_CW_ACC_HI:TIT_CW_ACC_LO];
            assign cfg_we = wr && addr == TIT_ADDR_CTRL && ctl_sel == 2'(g)
                            && wdata[TIT_CW_ACC_HI:TIT_CW_ACC_LO] != TIT_ACC_LATCH;
            assign wr_cnt = wr && addr == 2'(g);
            assign load   = wr_cnt && (acc != TIT_ACC_WORD || wflip_r[g]);
            assign load_val = (acc == TIT_ACC_LSB) ? {8'h00, wdata} :
                              (acc == TIT_ACC_MSB) ? {wdata, 8'h00} : {wdata, lsb_r[g]};
            // Event function takes its count clock from the event input
            assign tick = (cw_r[g][TIT_CW_FN_HI:TIT_CW_FN_LO] == TIT_FN_EVENT)
                          ? evt_rise[g] : clk_rise[g];

            tit_sync u_clk (
                .clk   (clk),
                .rst_n (rst_n),
                .pin   (cnt_clk[g]),
                .level (),
                .rise  (clk_rise[g])
            );

            tit_sync u_evt (
                .clk   (clk),
                .rst_n (rst_n),
                .pin   (evt_in[g]),
                .level (),
                .rise  (evt_rise[g])
            );

            tit_sync u_gate (
                .clk   (clk),
                .rst_n (rst_n),
                .pin   (cnt_gate[g]),
                .level (gate_lvl[g]),
                .rise  (gate_rise[g])
            );

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cw_r[g] <= TIT_CW_RESET;
                end else if (cfg_we) begin
                    cw_r[g] <= wdata;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lsb_r[g]   <= 8'h00;
                    wflip_r[g] <= 1'b0;
                end else if (cfg_we) begin
                    wflip_r[g] <= 1'b0;
                end else if (wr_cnt && acc == TIT_ACC_WORD) begin
                    if (!wflip_r[g]) begin
                        lsb_r[g] <= wdata;
                    end
                    wflip_r[g] <= ~wflip_r[g];
                end
            end

            // Latch command freezes a snapshot until it has been read out or a new control word reprograms the counter
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    latch_r[g]   <= TIT_COUNT_RESET;
                    latched_r[g] <= 1'b0;
                end else if (wr && addr == TIT_ADDR_CTRL && ctl_sel == 2'(g)
                             && wdata[TIT_CW_ACC_HI:TIT_CW_ACC_LO] == TIT_ACC_LATCH
                             && !latched_r[g]) begin
                    latch_r[g]   <= count[g];
                    latched_r[g] <= 1'b1;
                end else if (cfg_we) begin
                    latched_r[g] <= 1'b0;
                end else if (rd && addr == 2'(g)
                             && (acc != TIT_ACC_WORD || rflip_r[g])) begin
                    latched_r[g] <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    rflip_r[g] <= 1'b0;
                end else if (cfg_we) begin
                    rflip_r[g] <= 1'b0;
                end else if (rd && addr == 2'(g) && acc == TIT_ACC_WORD) begin
                    rflip_r[g] <= ~rflip_r[g];
                end
            end

            tit_counter #(
                .WIDTH (16)
            ) u_cnt (
                .clk       (clk),
                .rst_n     (rst_n),
                .cfg_we    (cfg_we),
                .cfg_fn    (wdata[TIT_CW_FN_HI:TIT_CW_FN_LO]),
                .cfg_bcd   (wdata[TIT_CW_BCD_BIT]),
                .load      (load),
                .load_val  (load_val),
                .sw_trig   (load),
                .tick      (tick),
                .gate      (gate_lvl[g]),
                .gate_rise (gate_rise[g]),
                .count     (count[g]),
                .out       (cnt_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                TIT_ADDR_CNT0, TIT_ADDR_CNT1, TIT_ADDR_CNT2: begin
                    rdata_r <= tit_pick(latched_r[addr] ? latch_r[addr] : count[addr],
                                        cw_r[addr][TIT_CW_ACC_HI:TIT_CW_ACC_LO],
                                        rflip_r[addr]);
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end

    assign rdata    = rdata_r;
    assign baud_clk = cnt_out[2];
endmodule

// [sim/tit_props.sv]
// Port checker of the triple interval timer
`timescale 1ns/1ps
module tit_props
    import tit_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [2:0] cnt_clk,
    input wire logic [2:0] cnt_gate,
    input wire logic [2:0] evt_in,
    input wire logic [2:0] cnt_out,
    input wire logic       baud_clk
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ----
    // Cycles since counter 0 was last disturbed
    // ----
    logic [2:0] pin0_r;
    logic [3:0] quiet0_r;
    logic       touch0;

    assign touch0 = wr && (addr == TIT_ADDR_CNT0 ||
                           (addr == TIT_ADDR_CTRL && wdata[7:6] == 2'h0));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin0_r   <= 3'h0;
            quiet0_r <= 4'h0;
        end else begin
            pin0_r <= {cnt_clk[0], cnt_gate[0], evt_in[0]};
            if (touch0 || pin0_r != {cnt_clk[0], cnt_gate[0], evt_in[0]}) begin
                quiet0_r <= 4'h0;
            end else if (quiet0_r != 4'hF) begin
                quiet0_r <= quiet0_r + 4'h1;
            end
        end
    end

    // ----
    // Properties
    // ----
    sequence cfg0_s(fn);
        wr && addr == TIT_ADDR_CTRL && wdata[7:6] == 2'h0 &&
            wdata[5:4] != TIT_ACC_LATCH && wdata[3:1] == fn;
    endsequence

    property hold0_p(cond);
        quiet0_r >= 4'h8 && !touch0 && cond |=> $stable(cnt_out[0]);
    endproperty

    baud_copy_a:
        assert property (baud_clk == cnt_out[2])
        else $error("baud clock differs from counter 2 output");
    reset_idle_a:
        assert property (disable iff (1'b0) !rst_n |-> cnt_out == 3'h7 && rdata == 8'h00)
        else $error("outputs not idle in reset");
    ctrl_read_zero_a:
        assert property (rd && addr == TIT_ADDR_CTRL |=> rdata == 8'h00)
        else $error("control address read not zero");
    rdata_hold_a:
        assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
    tc_arm_low_a:
        assert property (cfg0_s(TIT_FN_TC_IRQ) |=> !cnt_out[0])
        else $error("terminal count output not low after setup");
    evt_arm_low_a:
        assert property (cfg0_s(TIT_FN_EVENT) |=> !cnt_out[0])
        else $error("event output not low after setup");
    other_cfg_a:
        assert property (hold0_p(wr && addr == TIT_ADDR_CTRL && wdata[7:6] != 2'h0))
        else $error("counter 0 output moved on another counter setup");
    quiet_out_a:
        assert property (hold0_p(1'b1))
        else $error("counter 0 output moved without a cause");
endmodule

bind tit_top tit_props tit_props_u (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .evt_in(evt_in), .cnt_out(cnt_out),
    .baud_clk(baud_clk)
);

// [sim/test_tit_top.sv]
// Self-checking bench for the triple interval timer
`timescale 1ns/1ps
module test_tit_top
    import tit_pkg::*;
;
    logic       clk;
    logic       rst_n;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [2:0] cnt_clk;
    logic [2:0] cnt_gate;
    logic [2:0] evt_in;
    logic [2:0] cnt_out;
    logic       baud_clk;
    int         mismatches;
    int         checked;

    tit_top dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                   .rdata(rdata), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .evt_in(evt_in),
                   .cnt_out(cnt_out), .baud_clk(baud_clk));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----
    // Access and stimulus tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic setup(input logic [1:0] c, input logic [2:0] fn, input logic bcd,
                         input logic [15:0] n);
        wr_reg(TIT_ADDR_CTRL, {c, TIT_ACC_WORD, fn, bcd});
        wr_reg(c, n[7:0]);
        wr_reg(c, n[15:8]);
    endtask

    task automatic rd16(input logic [1:0] c, input bit lat, output logic [15:0] v);
        if (lat) wr_reg(TIT_ADDR_CTRL, {c, TIT_ACC_LATCH, 4'h0});
        rd_reg(c, v[7:0]);
        rd_reg(c, v[15:8]);
    endtask

    // Pulses a count clock or event pin and counts samples with the output low
    task automatic ticks(input bit ev, input int i, input int n, output int lows);
        logic [2:0] m;
        m    = 3'h1 << i;
        lows = 0;
        repeat (n) begin
            @(posedge clk);
            evt_in  <= ev ? (evt_in | m) : evt_in;
            cnt_clk <= ev ? cnt_clk : (cnt_clk | m);
            repeat (3) @(posedge clk);
            evt_in  <= evt_in & ~m;
            cnt_clk <= cnt_clk & ~m;
            repeat (3) @(posedge clk);
            #1;
            lows += int'(cnt_out[i] === 1'b0);
        end
    endtask

    task automatic trig(input int i);
        logic [2:0] m;
        m = 3'h1 << i;
        @(posedge clk);
        cnt_gate <= cnt_gate & ~m;
        repeat (3) @(posedge clk);
        cnt_gate <= cnt_gate | m;
        repeat (3) @(posedge clk);
    endtask

    task automatic out_is(input int i, input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, cnt_out[i]}, {15'h0, e});
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        logic [15:0] v;
        int          lows;
        mismatches = 0;
        checked    = 0;
        rst_n      = 1'b1;
        addr       = 2'h0;
        wdata      = 8'h00;
        wr         = 1'b0;
        rd         = 1'b0;
        cnt_clk    = 3'h0;
        cnt_gate   = 3'h7;
        evt_in     = 3'h0;
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({13'h0, cnt_out}, 16'h0007);
        @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(TIT_ADDR_CTRL, v[7:0]);
        chk({8'h00, v[7:0]}, 16'h0000);
        setup(2'h0, TIT_FN_TC_IRQ, 1'b0, 16'h0105);
        ticks(0, 0, 3, lows);
        wr_reg(TIT_ADDR_CTRL, {2'h0, TIT_ACC_LATCH, 4'h0});
        ticks(0, 0, 1, lows);
        rd16(2'h0, 0, v);
        chk(v, 16'h0102);
        @(posedge clk);
        cnt_gate <= 3'h6;
        ticks(0, 0, 2, lows);
        rd16(2'h0, 0, v);
        chk(v, 16'h0101);
        @(posedge clk);
        cnt_gate <= 3'h7;
        ticks(0, 0, 256, lows);
        chk(lows[15:0], 16'h0100);
        ticks(0, 0, 1, lows);
        chk(lows[15:0], 16'h0000);
        setup(2'h1, TIT_FN_TC_IRQ, 1'b1, 16'h0100);
        ticks(0, 1, 1, lows);
        rd16(2'h1, 1, v);
        chk(v, 16'h0099);
        rd16(2'h0, 0, v);
        chk(v, 16'h0000);
        out_is(0, 1'b1);
        ticks(0, 1, 98, lows);
        rd16(2'h1, 1, v);
        chk(v, 16'h0001);
        setup(2'h2, TIT_FN_RATE, 1'b0, 16'h0004);
        ticks(0, 2, 2, lows);
        ticks(0, 2, 12, lows);
        chk(lows[15:0], 16'h0003);
        setup(2'h2, TIT_FN_SQUARE, 1'b0, 16'h0006);
        ticks(0, 2, 2, lows);
        ticks(0, 2, 12, lows);
        chk(lows[15:0], 16'h0006);
        setup(2'h2, TIT_FN_SQUARE, 1'b0, 16'h0005);
        ticks(0, 2, 2, lows);
        ticks(0, 2, 10, lows);
        chk(lows[15:0], 16'h0004);
        ticks(0, 2, 1, lows);
        chk({15'h0, baud_clk}, 16'h0000);
        wr_reg(TIT_ADDR_CTRL, {2'h2, TIT_ACC_LSB, TIT_FN_TC_IRQ, 1'b0});
        wr_reg(2'h2, 8'h5A);
        rd_reg(2'h2, v[7:0]);
        chk({8'h00, v[7:0]}, 16'h005A);
        wr_reg(TIT_ADDR_CTRL, {2'h2, TIT_ACC_MSB, TIT_FN_TC_IRQ, 1'b0});
        rd_reg(2'h2, v[7:0]);
        chk({8'h00, v[7:0]}, 16'h0000);
        wr_reg(2'h2, 8'hA5);
        rd_reg(2'h2, v[7:0]);
        chk({8'h00, v[7:0]}, 16'h00A5);
        setup(2'h0, TIT_FN_SW_STB, 1'b0, 16'h0003);
        out_is(0, 1'b1);
        ticks(0, 0, 6, lows);
        chk(lows[15:0], 16'h0001);
        setup(2'h1, TIT_FN_HW_STB, 1'b0, 16'h0003);
        ticks(0, 1, 5, lows);
        chk(lows[15:0], 16'h0000);
        trig(1);
        ticks(0, 1, 2, lows);
        chk(lows[15:0], 16'h0000);
        trig(1);
        ticks(0, 1, 2, lows);
        chk(lows[15:0], 16'h0000);
        ticks(0, 1, 4, lows);
        chk(lows[15:0], 16'h0001);
        setup(2'h1, TIT_FN_ONESHOT, 1'b0, 16'h0004);
        ticks(0, 1, 5, lows);
        chk(lows[15:0], 16'h0003);
        trig(1);
        ticks(0, 1, 2, lows);
        chk(lows[15:0], 16'h0002);
        trig(1);
        ticks(0, 1, 3, lows);
        chk(lows[15:0], 16'h0003);
        ticks(0, 1, 3, lows);
        out_is(1, 1'b1);
        setup(2'h0, TIT_FN_EVENT, 1'b0, 16'h0003);
        ticks(0, 0, 3, lows);
        rd16(2'h0, 1, v);
        chk(v, 16'h0003);
        ticks(1, 0, 2, lows);
        rd16(2'h0, 1, v);
        chk(v, 16'h0001);
        ticks(1, 0, 1, lows);
        out_is(0, 1'b1);
        tally_and_finish();
    end

    initial begin
        #2_000_000;
        mismatches++;
        tally_and_finish();
    end
endmodule
